// ---- src/mpm_pkg.sv ----
// Constants, encodings and timing for the paged management memory block
package mpm_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned RESET_MIN_NS = 10000;
	localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [10:0] RESET_CNT_FIRE = 11'(RESET_MIN_CYC - 1);
	localparam logic [10:0] RESET_CNT_MAX = 11'(RESET_MIN_CYC);

	// ----------------------------------------------------------------
	// Serial bus
	// ----------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h50;
	localparam logic [3:0] RX_BITS = 4'h8;
	localparam logic [3:0] TX_LAST_BIT = 4'h7;

	// ----------------------------------------------------------------
	// Memory map
	// ----------------------------------------------------------------
	localparam int unsigned REGION_BYTES = 128;
	localparam int unsigned SLOT_COUNT = 7;
	localparam int unsigned FLAG_BYTES = 4;
	localparam logic [7:0] STATUS_ADDR = 8'h03;
	localparam logic [7:0] FLAG_BASE = 8'h08;
	localparam logic [7:0] FLAG_END = 8'h0C;
	localparam logic [7:0] BANK_SEL_ADDR = 8'h7E;
	localparam logic [7:0] PAGE_SEL_ADDR = 8'h7F;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int unsigned STATUS_LP_BIT = 0;
	localparam int unsigned STATUS_INT_BIT = 1;

	localparam logic [7:0] PAGE_00 = 8'h00;
	localparam logic [7:0] PAGE_01 = 8'h01;
	localparam logic [7:0] PAGE_02 = 8'h02;
	localparam logic [7:0] PAGE_10 = 8'h10;
	localparam logic [7:0] PAGE_11 = 8'h11;
	localparam logic [7:0] BANK_0 = 8'h00;
	localparam logic [7:0] BANK_1 = 8'h01;

	// Storage slot of each implemented page and bank
	localparam logic [2:0] SLOT_P00 = 3'h0;
	localparam logic [2:0] SLOT_P01 = 3'h1;
	localparam logic [2:0] SLOT_P02 = 3'h2;
	localparam logic [2:0] SLOT_P10_B0 = 3'h3;
	localparam logic [2:0] SLOT_P11_B0 = 3'h4;
	localparam logic [2:0] SLOT_P10_B1 = 3'h5;
	localparam logic [2:0] SLOT_P11_B1 = 3'h6;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MPM_IDLE = 3'b000,
		MPM_RX = 3'b001,
		MPM_RACK = 3'b010,
		MPM_TX = 3'b011,
		MPM_TACK = 3'b100
	} mpm_state_e;

	typedef enum logic [1:0] {
		MPM_PH_ADDR = 2'b00,
		MPM_PH_OFFS = 2'b01,
		MPM_PH_DATA = 2'b10
	} mpm_phase_e;

endpackage

// ---- src/mpm_mem_if.sv ----
// Byte access path between the serial engine and the management memory
`timescale 1ns/100ps
interface mpm_mem_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic we;
	logic re;
	logic [7:0] rdata;

	modport engine (output addr, output wdata, output we, output re, input rdata);
	modport mem (input addr, input wdata, input we, input re, output rdata);
endinterface

// ---- src/mpm_serial_slave.sv ----
// Two-wire serial slave engine with byte pointer and select gating
`timescale 1ns/100ps
module mpm_serial_slave
	import mpm_pkg::*;
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Select, already synchronised
	input wire logic i_select_n,
	// Serial pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	// Memory side
	mpm_mem_if.engine mem
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic scl_m_q, scl_s_q, scl_p_q;
	logic sda_m_q, sda_s_q, sda_p_q;

	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_m_q <= i_scl;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= i_sda;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_s_q & ~scl_p_q;
	assign scl_fall = ~scl_s_q & scl_p_q;
	assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

	// ----------------------------------------------------------------
	// Protocol state
	// ----------------------------------------------------------------
	mpm_state_e st_q, st_d;
	mpm_phase_e ph_q, ph_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] ptr_q, ptr_d;
	logic rw_q, rw_d;
	logic nack_q, nack_d;
	logic oe_n_q, oe_n_d;
	logic we, re;

	always_comb
	begin
		st_d = st_q;
		ph_d = ph_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		nack_d = nack_q;
		we = 1'b0;
		re = 1'b0;
		// A deselected module neither answers nor acknowledges
		if (i_select_n)
			st_d = MPM_IDLE;
		else if (bus_start)
		begin
			st_d = MPM_RX;
			ph_d = MPM_PH_ADDR;
			cnt_d = '0;
		end
		else if (bus_stop)
			st_d = MPM_IDLE;
		else
		begin
			case (st_q)
				MPM_RX:
				begin
					if (scl_rise)
					begin
						sh_d = {sh_q[6:0], sda_s_q};
						cnt_d = 4'(cnt_q + 4'h1);
					end
					else if (scl_fall && cnt_q == RX_BITS)
					begin
						st_d = MPM_RACK;
						case (ph_q)
							MPM_PH_ADDR:
							begin
								if (sh_q[7:1] != DEV_ADDR)
									st_d = MPM_IDLE;
								rw_d = sh_q[0];
							end
							MPM_PH_OFFS:
								ptr_d = sh_q;
							default:
							begin
								we = 1'b1;
								ptr_d = 8'(ptr_q + 8'h01);
							end
						endcase
					end
				end
				MPM_RACK:
				begin
					if (scl_fall)
					begin
						cnt_d = '0;
						if (ph_q == MPM_PH_ADDR && rw_q)
						begin
							st_d = MPM_TX;
							ph_d = MPM_PH_DATA;
							sh_d = mem.rdata;
							re = 1'b1;
							ptr_d = 8'(ptr_q + 8'h01);
						end
						else
						begin
							st_d = MPM_RX;
							ph_d = (ph_q == MPM_PH_ADDR) ? MPM_PH_OFFS : MPM_PH_DATA;
						end
					end
				end
				MPM_TX:
				begin
					if (scl_fall)
					begin
						if (cnt_q == TX_LAST_BIT)
							st_d = MPM_TACK;
						else
						begin
							sh_d = {sh_q[6:0], 1'b0};
							cnt_d = 4'(cnt_q + 4'h1);
						end
					end
				end
				MPM_TACK:
				begin
					if (scl_rise)
						nack_d = sda_s_q;
					else if (scl_fall)
					begin
						if (nack_q)
							st_d = MPM_IDLE;
						else
						begin
							st_d = MPM_TX;
							cnt_d = '0;
							sh_d = mem.rdata;
							re = 1'b1;
							ptr_d = 8'(ptr_q + 8'h01);
						end
					end
				end
				default:
					st_d = MPM_IDLE;
			endcase
		end
		oe_n_d = ~((st_d == MPM_RACK) | ((st_d == MPM_TX) & ~sh_d[7]));
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			st_q <= MPM_IDLE;
			ph_q <= MPM_PH_ADDR;
			cnt_q <= '0;
			sh_q <= '0;
			ptr_q <= '0;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			oe_n_q <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
			ph_q <= ph_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign o_sda = 1'b0;
	assign o_sda_oe_n = oe_n_q;
	assign mem.addr = ptr_q;
	assign mem.wdata = sh_q;
	assign mem.we = we;
	assign mem.re = re;

endmodule

// ---- src/mpm_mgmt_memory.sv ----
// Paged management memory with sideband pins of a pluggable module
`timescale 1ns/100ps
module mpm_mgmt_memory
	import mpm_pkg::*;
#(
	parameter bit P_PAGED = 1'b1
)
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Sideband pins
	input wire logic i_low_power_request,
	input wire logic i_module_reset_n,
	input wire logic i_select_n,
	output logic o_presence_n,
	output logic o_interrupt_n,
	output logic o_interrupt_oe_n,
	// Serial pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	// Module events and power control
	input wire logic [FLAG_BYTES*8-1:0] i_flag_event,
	output logic o_low_power_mode
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// The low-power pin has an internal pull-up, so an open pin arrives as one
	logic lp_m_q, lp_s_q, rst_m_q, rst_s_q, sel_m_q, sel_s_q;

	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			lp_m_q <= 1'b1;
			lp_s_q <= 1'b1;
			rst_m_q <= 1'b1;
			rst_s_q <= 1'b1;
			sel_m_q <= 1'b1;
			sel_s_q <= 1'b1;
		end
		else
		begin
			lp_m_q <= i_low_power_request;
			lp_s_q <= lp_m_q;
			rst_m_q <= i_module_reset_n;
			rst_s_q <= rst_m_q;
			sel_m_q <= i_select_n;
			sel_s_q <= sel_m_q;
		end
	end

	// ----------------------------------------------------------------
	// Serial engine
	// ----------------------------------------------------------------
	mpm_mem_if mem ();

	mpm_serial_slave u_slave (
		.i_ref_clk (i_ref_clk),
		.i_resetn (i_resetn),
		.i_select_n (sel_s_q),
		.i_scl (i_scl),
		.i_sda (i_sda),
		.o_sda (o_sda),
		.o_sda_oe_n (o_sda_oe_n),
		.mem (mem)
	);

	// ----------------------------------------------------------------
	// Module reset pulse filter
	// ----------------------------------------------------------------
	// Short glitches on the reset pin are ignored; only a full-length pulse clears settings
	logic [10:0] rcnt_q, rcnt_d;
	logic soft_rst_q, soft_rst_d;
	logic lp_q, lp_d;

	always_comb
	begin
		rcnt_d = rcnt_q;
		soft_rst_d = 1'b0;
		lp_d = lp_s_q;
		if (rst_s_q)
			rcnt_d = '0;
		else if (rcnt_q != RESET_CNT_MAX)
			rcnt_d = 11'(rcnt_q + 11'h001);
		if (!rst_s_q && rcnt_q == RESET_CNT_FIRE)
			soft_rst_d = 1'b1;
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rcnt_q <= '0;
			soft_rst_q <= 1'b0;
			lp_q <= 1'b1;
		end
		else
		begin
			rcnt_q <= rcnt_d;
			soft_rst_q <= soft_rst_d;
			lp_q <= lp_d;
		end
	end

	// ----------------------------------------------------------------
	// Page and bank mapping
	// ----------------------------------------------------------------
	logic [7:0] lower_q [REGION_BYTES];
	logic [7:0] lower_d [REGION_BYTES];
	logic [7:0] page_q [SLOT_COUNT*REGION_BYTES];
	logic [7:0] page_d [SLOT_COUNT*REGION_BYTES];
	logic [7:0] sel_page, sel_bank;
	logic [2:0] slot;
	logic slot_ok;
	logic [9:0] up_idx;

	assign sel_page = lower_q[PAGE_SEL_ADDR[6:0]];
	assign sel_bank = lower_q[BANK_SEL_ADDR[6:0]];

	// Selection is read live from storage, so a new value takes effect at once
	always_comb
	begin
		slot = SLOT_P00;
		slot_ok = 1'b1;
		if (P_PAGED)
		begin
			case (sel_page)
				PAGE_00: slot = SLOT_P00;
				PAGE_01: slot = SLOT_P01;
				PAGE_02: slot = SLOT_P02;
				PAGE_10, PAGE_11:
				begin
					if (sel_bank == BANK_0)
						slot = (sel_page == PAGE_10) ? SLOT_P10_B0 : SLOT_P11_B0;
					else if (sel_bank == BANK_1)
						slot = (sel_page == PAGE_10) ? SLOT_P10_B1 : SLOT_P11_B1;
					else
						slot_ok = 1'b0;
				end
				default: slot_ok = 1'b0;
			endcase
		end
	end

	assign up_idx = {slot, mem.addr[6:0]};

	// ----------------------------------------------------------------
	// Interrupt flags
	// ----------------------------------------------------------------
	logic [7:0] flag_q [FLAG_BYTES];
	logic [7:0] flag_d [FLAG_BYTES];
	logic in_flags;
	logic [7:0] flag_off;

	assign in_flags = (mem.addr >= FLAG_BASE) && (mem.addr < FLAG_END);
	assign flag_off = 8'(mem.addr - FLAG_BASE);

	genvar gi;
	generate
		for (gi = 0; gi < FLAG_BYTES; gi++)
		begin : g_flag
			// Read clears a byte, but a new event in the same cycle still sets it
			always_comb
			begin
				flag_d[gi] = flag_q[gi];
				if (mem.re && in_flags && flag_off == 8'(gi))
					flag_d[gi] = RESET_BYTE;
				flag_d[gi] = flag_d[gi] | i_flag_event[gi*8 +: 8];
				if (soft_rst_q)
					flag_d[gi] = RESET_BYTE;
			end

			always_ff @(posedge i_ref_clk or negedge i_resetn)
			begin
				if (!i_resetn)
					flag_q[gi] <= RESET_BYTE;
				else
					flag_q[gi] <= flag_d[gi];
			end
		end
	endgenerate

	logic any_flag;
	logic int_oe_n_q;

	always_comb
	begin
		any_flag = 1'b0;
		for (int k = 0; k < FLAG_BYTES; k++)
			any_flag = any_flag | (|flag_q[k]);
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			int_oe_n_q <= 1'b1;
		else
			int_oe_n_q <= ~any_flag;
	end

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	always_comb
	begin
		lower_d = lower_q;
		page_d = page_q;
		if (soft_rst_q)
		begin
			for (int k = 0; k < REGION_BYTES; k++)
				lower_d[k] = RESET_BYTE;
			for (int k = 0; k < SLOT_COUNT*REGION_BYTES; k++)
				page_d[k] = RESET_BYTE;
		end
		else if (mem.we)
		begin
			if (!mem.addr[7])
			begin
				if (!in_flags && mem.addr != STATUS_ADDR)
					lower_d[mem.addr[6:0]] = mem.wdata;
			end
			else if (slot_ok)
				page_d[up_idx] = mem.wdata;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			for (int k = 0; k < REGION_BYTES; k++)
				lower_q[k] <= RESET_BYTE;
			for (int k = 0; k < SLOT_COUNT*REGION_BYTES; k++)
				page_q[k] <= RESET_BYTE;
		end
		else
		begin
			lower_q <= lower_d;
			page_q <= page_d;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [7:0] status_byte;

	always_comb
	begin
		status_byte = RESET_BYTE;
		status_byte[STATUS_LP_BIT] = lp_q;
		status_byte[STATUS_INT_BIT] = int_oe_n_q;
		if (!mem.addr[7])
		begin
			if (in_flags)
				mem.rdata = flag_q[flag_off[1:0]];
			else if (mem.addr == STATUS_ADDR)
				mem.rdata = status_byte;
			else
				mem.rdata = lower_q[mem.addr[6:0]];
		end
		else if (slot_ok)
			mem.rdata = page_q[up_idx];
		else
			mem.rdata = RESET_BYTE;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_presence_n = 1'b0;
	assign o_interrupt_n = 1'b0;
	assign o_interrupt_oe_n = int_oe_n_q;
	assign o_low_power_mode = lp_q;

endmodule

// ---- tb/mpm_mgmt_memory_assertions.sv ----
// Pin-level checks bound to the paged management memory
`timescale 1ns/100ps
module mpm_mgmt_memory_assertions
	import mpm_pkg::*;
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Sideband pins
	input wire logic i_low_power_request,
	input wire logic i_module_reset_n,
	input wire logic i_select_n,
	input wire logic o_presence_n,
	input wire logic o_interrupt_n,
	input wire logic o_interrupt_oe_n,
	// Serial pins
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe_n,
	// Events and power
	input wire logic [FLAG_BYTES*8-1:0] i_flag_event,
	input wire logic o_low_power_mode
);
	// Check point leaves slack for the pin synchroniser and clear pulse
	localparam int RST_CHK = RESET_MIN_CYC + 8;
	logic [11:0] cnt_d;
	logic [11:0] cnt_q;
	always_comb
	begin
		cnt_d = 12'h000;
		if (!i_module_reset_n && i_flag_event == '0)
			cnt_d = (cnt_q == 12'(RST_CHK)) ? cnt_q : cnt_q + 12'h001;
	end
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			cnt_q <= 12'h000;
		else
			cnt_q <= cnt_d;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	a_presence_low: assert property (o_presence_n == 1'b0)
		else $error("presence output not low");
	a_int_data_low: assert property (o_interrupt_n == 1'b0)
		else $error("interrupt data value not low");
	a_int_on_flag: assert property (i_flag_event != '0 |-> ##[1:2] !o_interrupt_oe_n)
		else $error("interrupt not pulled after flag event");
	a_int_release_clean: assert property ($rose(o_interrupt_oe_n) |-> $past(i_flag_event, 2) == '0)
		else $error("interrupt released over a fresh flag");
	a_no_read_release: assert property ((i_select_n && i_module_reset_n) [*8] |-> !$rose(o_interrupt_oe_n))
		else $error("interrupt released while deselected");
	a_lp_high: assert property (i_low_power_request [*5] |-> o_low_power_mode)
		else $error("low power mode not high");
	a_lp_low: assert property (!i_low_power_request [*5] |-> !o_low_power_mode)
		else $error("low power mode not low");
	a_select_quiet: assert property (i_select_n [*5] |-> o_sda_oe_n)
		else $error("data line pulled while deselected");
	a_sda_clock_low: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl))
		else $error("data line changed while clock high");
	a_reset_clears: assert property (cnt_q == 12'(RST_CHK) |-> o_interrupt_oe_n)
		else $error("long module reset left interrupt pulled");
endmodule
bind mpm_mgmt_memory mpm_mgmt_memory_assertions u_chk (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
	.i_low_power_request(i_low_power_request), .i_module_reset_n(i_module_reset_n), .i_select_n(i_select_n),
	.o_presence_n(o_presence_n), .o_interrupt_n(o_interrupt_n), .o_interrupt_oe_n(o_interrupt_oe_n),
	.i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_flag_event(i_flag_event),
	.o_low_power_mode(o_low_power_mode));

// ---- tb/mpm_host_model.sv ----
// Host management controller model on the two-wire serial bus
`timescale 1ns/100ps
module mpm_host_model
	import mpm_pkg::*;
(
	// Clock
	input wire logic i_ref_clk,
	// Resolved data line
	input wire logic i_sda,
	// Bus drive; a high pull holds the data line low
	output logic o_scl,
	output logic o_sda_pull
);
	initial
	begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	// Data moves only while the clock is low, so no false start or stop
	task automatic bit_io(input logic b, output logic r);
		o_sda_pull <= ~b;
		hold(5);
		o_scl <= 1'b1;
		hold(5);
		r = i_sda;
		o_scl <= 1'b0;
		hold(3);
	endtask
	task automatic start();
		o_sda_pull <= 1'b1;
		hold(5);
		o_scl <= 1'b0;
		hold(3);
	endtask
	task automatic restart();
		o_sda_pull <= 1'b0;
		hold(5);
		o_scl <= 1'b1;
		hold(5);
		start();
	endtask
	task automatic stop();
		o_sda_pull <= 1'b1;
		hold(5);
		o_scl <= 1'b1;
		hold(5);
		o_sda_pull <= 1'b0;
		hold(5);
	endtask
	task automatic send(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(v[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	// Single byte read, ended by a host NACK
	task automatic recv(output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			v[i] = r;
		end
		bit_io(1'b1, r);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic ok);
		logic k0;
		logic k1;
		logic k2;
		start();
		send({DEV_ADDR, 1'b0}, k0);
		send(a, k1);
		send(v, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask
	// Flag bytes are found by reading their offsets after an interrupt
	task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic ok);
		logic k0;
		logic k1;
		logic k2;
		start();
		send({DEV_ADDR, 1'b0}, k0);
		send(a, k1);
		restart();
		send({DEV_ADDR, 1'b1}, k2);
		recv(v);
		stop();
		ok = k0 & k1 & k2;
	endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the paged management memory
`timescale 1ns/100ps
module tb_top;
	import mpm_pkg::*;
	localparam logic [7:0] PG [7] = '{PAGE_00, PAGE_01, PAGE_02, PAGE_10, PAGE_11, PAGE_10, PAGE_11};
	localparam logic [7:0] BK [7] = '{BANK_0, BANK_0, BANK_0, BANK_0, BANK_0, BANK_1, BANK_1};
	logic clk;
	logic rstn;
	logic lp_req;
	logic mod_rst_n;
	logic sel_n;
	logic scl;
	logic sda_pull;
	logic sda_o;
	logic sda_oe_n;
	logic sda_o_flat;
	logic sda_oe_flat_n;
	logic sel_flat_n;
	logic prs_n;
	logic int_n;
	logic int_oe_n;
	logic lp_mode;
	logic [FLAG_BYTES*8-1:0] flag_ev;
	logic ok;
	logic [7:0] d;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	// Both lines have pull-ups; each party can only pull low
	wire logic sda = !(sda_pull || (!sda_oe_n && !sda_o) || (!sda_oe_flat_n && !sda_o_flat));
	wire logic int_line = int_oe_n ? 1'b1 : int_n;
	mpm_mgmt_memory #(.P_PAGED(1'b1)) u_dut (.i_ref_clk(clk), .i_resetn(rstn), .i_low_power_request(lp_req),
		.i_module_reset_n(mod_rst_n), .i_select_n(sel_n), .o_presence_n(prs_n), .o_interrupt_n(int_n),
		.o_interrupt_oe_n(int_oe_n), .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe_n(sda_oe_n),
		.i_flag_event(flag_ev), .o_low_power_mode(lp_mode));
	// Second module without paging shares the bus; only one is selected at a time
	mpm_mgmt_memory #(.P_PAGED(1'b0)) u_dut_flat (.i_ref_clk(clk), .i_resetn(rstn), .i_low_power_request(lp_req),
		.i_module_reset_n(mod_rst_n), .i_select_n(sel_flat_n), .o_presence_n(), .o_interrupt_n(),
		.o_interrupt_oe_n(), .i_scl(scl), .i_sda(sda), .o_sda(sda_o_flat), .o_sda_oe_n(sda_oe_flat_n),
		.i_flag_event(flag_ev), .o_low_power_mode());
	mpm_host_model u_host (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(sda_pull));
	always #4 clk = ~clk;
	task automatic print_verdict();
		$display("Compares %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr_chk(input logic [7:0] a, input logic [7:0] v);
		u_host.wr(a, v, ok);
		chk("write ack", 8'h01, {7'h00, ok});
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] v, input string name);
		u_host.rd(a, d, ok);
		chk("read ack", 8'h01, {7'h00, ok});
		chk(name, v, d);
	endtask
	task automatic t_lower();
		chk("presence", 8'h00, {7'h00, prs_n});
		wr_chk(8'h05, 8'hA5);
		rd_chk(8'h05, 8'hA5, "lower byte");
		wr_chk(8'hFE, 8'h3C);
		rd_chk(8'hFE, 8'h3C, "upper byte");
	endtask
	task automatic t_paging();
		for (int i = 0; i < 7; i++)
		begin
			wr_chk(BANK_SEL_ADDR, BK[i]);
			wr_chk(PAGE_SEL_ADDR, PG[i]);
			wr_chk(8'h80, 8'hC0 + 8'(i));
		end
		for (int i = 0; i < 7; i++)
		begin
			wr_chk(BANK_SEL_ADDR, BK[i]);
			wr_chk(PAGE_SEL_ADDR, PG[i]);
			rd_chk(8'h80, 8'hC0 + 8'(i), "page byte");
			rd_chk(8'h05, 8'hA5, "lower byte");
		end
		wr_chk(PAGE_SEL_ADDR, 8'h03);
		wr_chk(8'h80, 8'h77);
		rd_chk(8'h80, 8'h00, "unmapped page");
		wr_chk(PAGE_SEL_ADDR, PAGE_00);
		wr_chk(BANK_SEL_ADDR, BANK_0);
	endtask
	task automatic t_interrupt();
		flag_ev <= 32'h003C_0081;
		@(posedge clk);
		flag_ev <= '0;
		repeat (3) @(posedge clk);
		chk("interrupt line", 8'h00, {7'h00, int_line});
		rd_chk(STATUS_ADDR, 8'h01, "status asserted");
		rd_chk(FLAG_BASE, 8'h81, "flag byte 0");
		chk("interrupt held", 8'h00, {7'h00, int_line});
		rd_chk(FLAG_BASE + 8'h02, 8'h3C, "flag byte 2");
		chk("interrupt released", 8'h01, {7'h00, int_line});
		rd_chk(FLAG_BASE, 8'h00, "flag cleared");
	endtask
	task automatic t_low_power();
		lp_req <= 1'b0;
		repeat (6) @(posedge clk);
		chk("low power mode", 8'h00, {7'h00, lp_mode});
		rd_chk(STATUS_ADDR, 8'h02, "status low power");
		lp_req <= 1'b1;
		repeat (6) @(posedge clk);
		chk("low power mode", 8'h01, {7'h00, lp_mode});
	endtask
	task automatic t_select();
		flag_ev <= 32'h0000_0001;
		sel_n <= 1'b1;
		@(posedge clk);
		flag_ev <= '0;
		repeat (8) @(posedge clk);
		u_host.wr(8'h05, 8'h11, ok);
		chk("deselected ack", 8'h00, {7'h00, ok});
		u_host.rd(FLAG_BASE, d, ok);
		chk("deselected read ack", 8'h00, {7'h00, ok});
		chk("interrupt kept", 8'h00, {7'h00, int_line});
		sel_n <= 1'b0;
		repeat (8) @(posedge clk);
		rd_chk(8'h05, 8'hA5, "lower kept");
		rd_chk(FLAG_BASE, 8'h01, "flag after select");
		chk("interrupt released", 8'h01, {7'h00, int_line});
	endtask
	// A flat module ignores the page select, so page 01h writes land in page 00h
	task automatic t_flat();
		sel_n <= 1'b1;
		sel_flat_n <= 1'b0;
		repeat (8) @(posedge clk);
		wr_chk(PAGE_SEL_ADDR, PAGE_01);
		wr_chk(8'h80, 8'h5A);
		wr_chk(PAGE_SEL_ADDR, PAGE_00);
		rd_chk(8'h80, 8'h5A, "flat upper byte");
		sel_flat_n <= 1'b1;
		sel_n <= 1'b0;
		repeat (8) @(posedge clk);
		rd_chk(8'h80, 8'hC0, "deselected kept");
	endtask
	task automatic t_mod_reset();
		mod_rst_n <= 1'b0;
		repeat (100) @(posedge clk);
		mod_rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		rd_chk(8'h05, 8'hA5, "short reset");
		wr_chk(PAGE_SEL_ADDR, PAGE_01);
		flag_ev <= 32'h0000_0100;
		@(posedge clk);
		flag_ev <= '0;
		mod_rst_n <= 1'b0;
		repeat (RESET_MIN_CYC + 20) @(posedge clk);
		mod_rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk("reset interrupt", 8'h01, {7'h00, int_line});
		rd_chk(8'h05, 8'h00, "long reset");
		rd_chk(PAGE_SEL_ADDR, 8'h00, "page select reset");
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 70000)
		begin
			bad_count++;
			print_verdict();
		end
	end
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		lp_req = 1'b1;
		mod_rst_n = 1'b1;
		sel_n = 1'b0;
		sel_flat_n = 1'b1;
		flag_ev = '0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		t_lower();
		t_paging();
		t_interrupt();
		t_low_power();
		t_select();
		t_flat();
		t_mod_reset();
		print_verdict();
	end
endmodule
